// file: src/sar_readout_map.svh
// register-free constants for the serial readout block
`ifndef SAR_READOUT_MAP_SVH
`define SAR_READOUT_MAP_SVH

`define RESULT_BITS      12
`define FULL_CYCLE_FALLS 16
`define SHORT_FALLS      14
`define SAMPLE_FALL      2
`define REPEAT_CUT_FALL  15
`define LAST_OUT_FALL    26
`define CODE_POS_FULL    12'h7ff
`define CODE_NEG_FULL    12'h800
`define CODE_ZERO        12'h000
`define FIFO_DEPTH       16

`endif

// file: src/sar_readout_pkg.sv
// types for the serial readout block
package sar_readout_pkg;

  typedef enum logic [4:0] {
    ST_IDLE    = 5'b00001,
    ST_SAMPLE  = 5'b00010,
    ST_CONVERT = 5'b00100,
    ST_REPEAT  = 5'b01000,
    ST_DONE    = 5'b10000
  } phase_e;

  typedef logic [11:0] code_t;

endpackage

// file: src/sample_fifo.sv
// parameterised valid/ready fifo for converter samples
`timescale 1ns/1ps
`default_nettype none

module sample_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic [WIDTH-1:0]      outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wrPtr;
    logic [AW:0] rdPtr;
    logic        ready;
  } fifo_s;

  fifo_s st_reg;
  fifo_s st_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             doWrite;
  logic             doRead;
  logic             isFull;
  logic             isEmpty;

  // occupancy flags; full kept registered so ready leaves a flop
  assign isEmpty  = (st_reg.wrPtr == st_reg.rdPtr);
  assign isFull   = !st_reg.ready;
  assign inReady  = st_reg.ready;
  assign outValid = !isEmpty;
  assign outData  = mem[st_reg.rdPtr[AW-1:0]];
  assign doWrite  = inValid && !isFull;
  assign doRead   = outReady && !isEmpty;

  // pointer update
  always_comb begin
    st_next = st_reg;
    if (doWrite) begin
      st_next.wrPtr = st_reg.wrPtr + 1'b1;
    end
    if (doRead) begin
      st_next.rdPtr = st_reg.rdPtr + 1'b1;
    end
    st_next.ready = !((st_next.wrPtr[AW-1:0] == st_next.rdPtr[AW-1:0]) &&
                      (st_next.wrPtr[AW] != st_next.rdPtr[AW]));
  end

  // state register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '{wrPtr: '0, rdPtr: '0, ready: 1'b1};
    end else begin
      st_reg <= st_next;
    end
  end

  // storage array
  always_ff @(posedge core_clk) begin
    if (doWrite) begin
      mem[st_reg.wrPtr[AW-1:0]] <= inData;
    end
  end
endmodule

`default_nettype wire

// file: src/pin_sync.sv
// two-stage synchroniser with edge detect after the second stage
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  input  wire logic core_clk,
  input  wire logic arst_n,
  input  wire logic pinIn,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } sync_s;

  sync_s st_reg;
  sync_s st_next;

  // shift chain; only sync and prev feed logic
  always_comb begin
    st_next      = st_reg;
    st_next.meta = pinIn;
    st_next.sync = st_reg.meta;
    st_next.prev = st_reg.sync;
  end

  // reset to the pin's idle level so no false edge after release
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= {3{RESET_LEVEL}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign level = st_reg.sync;
  assign rise  = st_reg.sync && !st_reg.prev;
  assign fall  = !st_reg.sync && st_reg.prev;
endmodule

`default_nettype wire

// file: src/sar_readout.sv
// conversion sequencer and three-wire serial readout of a 12-bit differential converter
`timescale 1ns/1ps
`default_nettype none
`include "sar_readout_map.svh"

// Behaviour
// - link is conversion-start low input, serial clock input, serial data output.
// - falling conversion-start begins a new conversion and its transfer.
// - input is sampled from start fall up to the second clock fall.
// - analog inputs are isolated while a conversion runs.
// - a full conversion cycle takes sixteen serial clock cycles.
// - short cycling gives fourteen or fifteen cycles, per first edge sense.
// - output enabled on second fall with null bit; MSB on third fall.
// - twelve result bits follow MSB first, from the running conversion.
// - output changes on clock fall; host captures on the next rise.
// - start held low repeats result LSB first, bit zero once, then release.
// - start high by fifteenth fall releases output after bit zero.
// - extra clocks do nothing; new conversion needs start high then low.
// - result is two's complement: 7ff, 000, fff, 800.
// - code saturates at 7ff and 800 near the reference limits.
// - converter powers down at start rise or at the fourteenth fall, in short and full cycles alike.
module sar_readout
  import sar_readout_pkg::*;
#(
  parameter int RESULT_BITS = `RESULT_BITS,
  parameter int FIFO_DEPTH  = `FIFO_DEPTH
) (
  input  wire logic                   core_clk,
  input  wire logic                   arst_n,
  input  wire logic                   convStartPin_n,
  input  wire logic                   serialClkPin,
  output logic                        serialDataOut,
  output logic                        serialDataOe,
  input  wire logic [RESULT_BITS-1:0] sampleCode,
  input  wire logic                   sampleValid,
  output logic                        sampleReady,
  output logic                        sampleHold,
  output logic                        inputIsolate,
  output logic                        analogPowered,
  output logic                        convBusy
);

  // =====================================================================
  // pin synchronisers
  // =====================================================================
  logic csLevel;
  logic csRise;
  logic csFall;
  logic sclkFall;

  // start line idles high
  pin_sync #(
    .RESET_LEVEL (1'b1)
  ) u_cs_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .pinIn    (convStartPin_n),
    .level    (csLevel),
    .rise     (csRise),
    .fall     (csFall)
  );

  // serial clock parks low between frames; only its falls matter
  pin_sync #(
    .RESET_LEVEL (1'b0)
  ) u_sclk_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .pinIn    (serialClkPin),
    .level    (),
    .rise     (),
    .fall     (sclkFall)
  );

  // =====================================================================
  // sample buffer between quantiser and shifter
  // =====================================================================
  logic [RESULT_BITS-1:0] fifoData;
  logic                   fifoValid;
  logic                   fifoTake;

  sample_fifo #(
    .WIDTH (RESULT_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .inData   (sampleCode),
    .inValid  (sampleValid),
    .inReady  (sampleReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (fifoTake)
  );

  // =====================================================================
  // state
  // =====================================================================
  typedef struct packed {
    phase_e                 phase;
    logic [4:0]             fallCnt;
    logic                   cutRepeat;
    logic [RESULT_BITS-1:0] result;
    logic                   dout;
    logic                   oe;
    logic                   hold;
    logic                   isolate;
    logic                   powered;
    logic                   busy;
  } core_s;

  core_s st_reg;
  core_s st_next;

  // index of the bit sent on a given fall count
  function automatic logic pick_msb(input logic [RESULT_BITS-1:0] v, input logic [4:0] n);
    logic [4:0] idx;
    idx = 5'(RESULT_BITS) - (n - 5'd2);
    return v[idx[3:0]];
  endfunction

  function automatic logic pick_lsb(input logic [RESULT_BITS-1:0] v, input logic [4:0] n);
    logic [4:0] idx;
    idx = n - 5'(`SAMPLE_FALL + RESULT_BITS); // fall 15 carries bit one
    return v[idx[3:0]];
  endfunction

  // =====================================================================
  // frame position decode
  // =====================================================================
  logic [4:0] nextFall;
  logic       atHoldFall;
  logic       inMsbSpan;
  logic       atRepeatEnd;
  logic       atShortEnd;
  logic       atFullEnd;

  // count that the clock fall now being seen completes
  assign nextFall    = st_reg.fallCnt + 5'd1;
  // second fall: input held and null bit driven
  assign atHoldFall  = (st_reg.fallCnt == 5'(`SAMPLE_FALL - 1));
  // falls three to fourteen carry the result msb first
  assign inMsbSpan   = (nextFall <= 5'(`SAMPLE_FALL + RESULT_BITS));
  // fall after the repeated bit eleven releases the line
  assign atRepeatEnd = (nextFall >= 5'(`LAST_OUT_FALL));
  // analog power-down points of the short and full cycle
  assign atShortEnd  = (nextFall == 5'(`SHORT_FALLS));
  assign atFullEnd   = (nextFall == 5'(`FULL_CYCLE_FALLS));

  // take a fresh sample when the hold point is reached
  assign fifoTake = (st_reg.phase == ST_SAMPLE) && sclkFall && atHoldFall && fifoValid;

  // =====================================================================
  // sequencer
  // =====================================================================
  always_comb begin
    st_next = st_reg;
    case (st_reg.phase)
      ST_IDLE: begin
        st_next.oe      = 1'b0;
        st_next.busy    = 1'b0;
        if (csFall) begin
          st_next.phase     = ST_SAMPLE;
          st_next.fallCnt   = 5'd0;
          st_next.cutRepeat = 1'b0;
          st_next.hold      = 1'b0;
          st_next.isolate   = 1'b0;
          st_next.powered   = 1'b1;
          st_next.busy      = 1'b1;
        end
      end
      ST_SAMPLE: begin
        if (csRise) begin
          st_next.phase   = ST_IDLE;
          st_next.powered = 1'b0;
        end else if (sclkFall) begin
          st_next.fallCnt = st_reg.fallCnt + 5'd1;
          if (atHoldFall) begin
            // second fall: hold input, drive null bit
            st_next.phase   = ST_CONVERT;
            st_next.hold    = 1'b1;
            st_next.isolate = 1'b1;
            st_next.result  = fifoValid ? fifoData : `CODE_ZERO;
            st_next.oe      = 1'b1;
            st_next.dout    = 1'b0;
          end
        end
      end
      ST_CONVERT: begin
        if (csRise) begin
          st_next.cutRepeat = 1'b1;
          st_next.powered   = 1'b0;
          st_next.isolate   = 1'b0;
        end
        if (sclkFall) begin
          st_next.fallCnt = st_reg.fallCnt + 5'd1;
          if (inMsbSpan) begin
            st_next.dout = pick_msb(st_reg.result, nextFall);
          end else if (st_reg.cutRepeat || csRise) begin
            // start already high: release after bit zero
            st_next.phase = ST_DONE;
            st_next.oe    = 1'b0;
          end else begin
            // bit zero is not sent twice; repeat opens with bit one
            st_next.phase = ST_REPEAT;
            st_next.dout  = pick_lsb(st_reg.result, nextFall);
          end
          if (atShortEnd) begin
            st_next.powered = 1'b0;
            st_next.isolate = 1'b0;
          end
        end
      end
      ST_REPEAT: begin
        if (csRise) begin
          st_next.phase = ST_IDLE;
          st_next.oe    = 1'b0;
        end else if (sclkFall) begin
          st_next.fallCnt = st_reg.fallCnt + 5'd1;
          if (atRepeatEnd) begin
            // bit eleven has stood one period; let the line go
            st_next.phase = ST_DONE;
            st_next.oe    = 1'b0;
          end else begin
            st_next.dout = pick_lsb(st_reg.result, nextFall);
          end
          if (atFullEnd) begin
            st_next.powered = 1'b0;
          end
        end
      end
      ST_DONE: begin
        // further clocks ignored until start goes high
        st_next.oe      = 1'b0;
        st_next.powered = 1'b0;
        st_next.isolate = 1'b0;
        if (csRise || csLevel) begin
          st_next.phase = ST_IDLE;
          st_next.busy  = 1'b0;
        end
      end
      default: begin
        st_next = '0;
        st_next.phase = ST_IDLE;
      end
    endcase
    if (st_reg.phase != ST_IDLE && st_reg.phase != ST_DONE && csRise && st_reg.phase != ST_CONVERT) begin
      st_next.hold = 1'b0;
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg       <= '0;
      st_reg.phase <= ST_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign serialDataOut = st_reg.dout;
  assign serialDataOe  = st_reg.oe;
  assign sampleHold    = st_reg.hold;
  assign inputIsolate  = st_reg.isolate;
  assign analogPowered = st_reg.powered;
  assign convBusy      = st_reg.busy;
endmodule

`default_nettype wire

// file: verification/sar_readout_chk.sv
// concurrent checks on the serial readout block ports
`timescale 1ns/1ps
`default_nettype none

// ==========
// checker
module sar_readout_chk (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic convStartPin_n,
  input wire logic serialClkPin,
  input wire logic serialDataOut,
  input wire logic serialDataOe,
  input wire logic sampleHold,
  input wire logic inputIsolate,
  input wire logic analogPowered,
  input wire logic convBusy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  logic [5:0] fallCnt_reg;

  // counts clock falls while the output is driven
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) fallCnt_reg <= 6'h00;
    else if (!serialDataOe) fallCnt_reg <= 6'h00;
    else if ($fell(serialClkPin)) fallCnt_reg <= fallCnt_reg + 6'h01;
  end

  reset_quiet_a: assert property ($rose(arst_n) |-> !serialDataOe && !convBusy && !analogPowered)
    else $error("outputs active right after reset");
  start_begins_a: assert property ($rose(convBusy) |-> !$past(convStartPin_n))
    else $error("frame began without a start fall");
  power_off_a: assert property ($rose(convStartPin_n) |-> ##[1:5] !analogPowered)
    else $error("converter still powered after start rose");
  oe_in_frame_a: assert property (serialDataOe |-> convBusy)
    else $error("output driven outside a frame");
  isolate_frame_a: assert property (inputIsolate |-> convBusy)
    else $error("inputs isolated outside a frame");
  hold_first_a: assert property ($rose(serialDataOe) |-> sampleHold && !serialDataOut)
    else $error("output enabled before hold or without null bit");
  shift_on_fall_a: assert property (
    serialDataOe && $past(serialDataOe) && $changed(serialDataOut)
    |-> !$past(serialClkPin) && !$past(serialClkPin, 2))
    else $error("data changed away from a clock fall");
  powered_start_a: assert property ($rose(convBusy) |-> analogPowered)
    else $error("frame began with converter powered down");
  isolate_hold_a: assert property ($rose(sampleHold) |-> inputIsolate)
    else $error("input held without isolation");
  oe_span_a: assert property (fallCnt_reg <= 6'h18)
    else $error("output driven for too many clock falls");
endmodule

bind sar_readout sar_readout_chk chk (
  .core_clk(core_clk), .arst_n(arst_n), .convStartPin_n(convStartPin_n),
  .serialClkPin(serialClkPin), .serialDataOut(serialDataOut), .serialDataOe(serialDataOe),
  .sampleHold(sampleHold), .inputIsolate(inputIsolate), .analogPowered(analogPowered),
  .convBusy(convBusy)
);

`default_nettype wire

// file: verification/host_model.sv
// host model: drives start and serial clock, captures the data line
`timescale 1ns/1ps
`default_nettype none

// ==========
// host
module host_model (
  input  wire logic core_clk,
  output logic      convStartPin_n,
  output logic      serialClkPin,
  input  wire logic serialDataOut,
  input  wire logic serialDataOe
);
  logic        capD [0:31];
  logic        capOe [0:31];
  logic        anyOe;
  logic        lastD = 1'b0;
  logic [11:0] word;
  // released line shows the inverse of the last driven bit
  wire         dataLine = serialDataOe ? serialDataOut : ~lastD;

  // idle: start high, clock parked low
  initial begin
    convStartPin_n = 1'b1;
    serialClkPin = 1'b0;
  end

  // remembers the last driven bit
  always @(posedge core_clk) if (serialDataOe) lastD <= serialDataOut;

  // half of a 400 ns serial period
  task automatic half();
    repeat (4) @(negedge core_clk);
  endtask

  // one frame of n falls; short frames raise start before fall 15
  task automatic frame(input int n, input bit holdLow);
    @(negedge core_clk);
    convStartPin_n = 1'b0; // clock low here
    for (int i = 1; i <= n; i++) begin
      half(); // leaves two periods before fall 2
      if (!holdLow && i == 15) convStartPin_n = 1'b1;
      serialClkPin = 1'b1;
      half();
      capD[i-1] = dataLine; // late in the high phase
      capOe[i-1] = serialDataOe;
      serialClkPin = 1'b0;
    end
    half();
    capD[n] = dataLine;
    capOe[n] = serialDataOe;
    convStartPin_n = 1'b1;
    repeat (2) half();
    for (int i = 0; i < 12; i++) word[11-i] = capD[i+3]; // null bit dropped
  endtask

  // clocks with start left high
  task automatic clocks(input int n);
    anyOe = 1'b0;
    repeat (n) begin
      half();
      serialClkPin = 1'b1;
      half();
      serialClkPin = 1'b0;
      anyOe = anyOe | serialDataOe;
    end
  endtask
endmodule

`default_nettype wire

// file: verification/sar_readout_tb_top.sv
// self-checking testbench for the serial readout block
`timescale 1ns/1ps
`default_nettype none
`include "sar_readout_map.svh"

`define CHK(a, b) begin samplesChecked++; if ((a) !== (b)) begin errors++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end

// ==========
// bench
module sar_readout_tb_top;
  import sar_readout_pkg::*;
  logic  core_clk = 1'b0;
  logic  arst_n = 1'b0;
  logic  convStartPin_n, serialClkPin, serialDataOut, serialDataOe;
  code_t sampleCode = 12'h000;
  logic  sampleValid = 1'b0;
  logic  sampleReady, sampleHold, inputIsolate, analogPowered, convBusy;
  int    errors = 0;
  int    samplesChecked = 0;

  // 50 ns core clock
  initial forever #25 core_clk = ~core_clk;

  sar_readout dut (.core_clk(core_clk), .arst_n(arst_n), .convStartPin_n(convStartPin_n),
    .serialClkPin(serialClkPin), .serialDataOut(serialDataOut), .serialDataOe(serialDataOe),
    .sampleCode(sampleCode), .sampleValid(sampleValid), .sampleReady(sampleReady),
    .sampleHold(sampleHold), .inputIsolate(inputIsolate), .analogPowered(analogPowered),
    .convBusy(convBusy));
  host_model host (.core_clk(core_clk), .convStartPin_n(convStartPin_n), .serialClkPin(serialClkPin),
    .serialDataOut(serialDataOut), .serialDataOe(serialDataOe));

  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", errors, samplesChecked);
    if (errors == 0 && samplesChecked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // offers one word to the buffer for one cycle
  task automatic push(input code_t c);
    @(negedge core_clk);
    sampleCode = c;
    sampleValid = 1'b1;
    @(negedge core_clk);
    sampleValid = 1'b0;
  endtask

  // runs a frame and judges the null bit, the result bits and the output enable around the frame
  task automatic check_frame(input code_t c, input bit holdLow);
    host.frame(holdLow ? 30 : 20, holdLow);
    `CHK(host.capOe[1], 1'b0)
    `CHK(host.capOe[2], 1'b1)
    `CHK(host.capD[2], 1'b0)
    `CHK(host.word, c)
    `CHK(host.capOe[14], 1'b1)
    if (holdLow) begin
      for (int i = 1; i < 12; i++) `CHK(host.capD[14+i], c[i])
      for (int i = 26; i <= 30; i++) `CHK(host.capOe[i], 1'b0)
    end else begin
      for (int i = 15; i <= 20; i++) `CHK(host.capOe[i], 1'b0)
    end
  endtask

  task automatic test_reset();
    `CHK(serialDataOe, 1'b0)
    `CHK(convBusy, 1'b0)
    `CHK(sampleReady, 1'b1)
  endtask

  task automatic test_codes();
    code_t codes [4] = '{`CODE_POS_FULL, `CODE_NEG_FULL, 12'hfff, `CODE_ZERO};
    foreach (codes[k]) begin
      push(codes[k]);
      check_frame(codes[k], 1'b1);
    end
  endtask

  task automatic test_short_and_idle();
    push(12'h5a3);
    check_frame(12'h5a3, 1'b0);
    host.clocks(20);
    `CHK(host.anyOe, 1'b0)
    `CHK(convBusy, 1'b0)
  endtask

  task automatic test_fifo();
    for (int i = 0; i < `FIFO_DEPTH; i++) begin
      `CHK(sampleReady, 1'b1)
      push(12'h100 + 12'(i));
    end
    `CHK(sampleReady, 1'b0)
    push(12'hbad);
    for (int i = 0; i < `FIFO_DEPTH; i++) check_frame(12'h100 + 12'(i), 1'b0);
    check_frame(`CODE_ZERO, 1'b0);
    `CHK(sampleReady, 1'b1)
  endtask

  // watchdog well beyond the expected run
  initial begin
    #2_000_000;
    errors++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    repeat (2) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    test_reset();
    test_codes();
    test_short_and_idle();
    test_fifo();
    tally_and_finish();
  end
endmodule

`default_nettype wire
